// *** core/php_port.sv ***
// Parallel host bus port with control register file and interrupt
`timescale 1ns/100ps
module php_port #(
   parameter int ADDR_W = php_pkg::ADDR_W,
   parameter int DATA_W = php_pkg::DATA_W
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Mode straps
   input wire logic [1:0] i_bus_interface_select,
   input wire logic i_bus_type_select,
   // Host bus controls
   input wire logic i_chip_select_n,
   input wire logic i_read_or_data_strobe_n,
   input wire logic i_write_or_read_write_n,
   input wire logic i_address_latch_strobe,
   input wire logic i_hardware_reset_n,
   input wire logic [ADDR_W-1:0] i_host_address_lines,
   // Host data lines, three signals per pin
   input wire logic [DATA_W-1:0] i_host_data_lines,
   output logic [DATA_W-1:0] o_host_data_lines,
   output logic o_host_data_lines_oe_n,
   // Interrupt, open drain
   output logic o_interrupt_n,
   output logic o_interrupt_oe_n,
   // Device side status and control
   input wire logic [DATA_W-1:0] i_status,
   output logic [DATA_W-1:0] o_ctrl_flat [1:2**ADDR_W-1]
);
   localparam int NREG = 2**ADDR_W;

   logic [DATA_W-1:0] ctrl [1:NREG-1];
   logic [DATA_W-1:0] next_ctrl [1:NREG-1];
   logic [ADDR_W-1:0] addr_latch;
   logic [ADDR_W-1:0] next_addr_latch;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] next_rd_data;
   logic [DATA_W-1:0] status_prev;
   logic [DATA_W-1:0] next_status_prev;
   logic [DATA_W-1:0] change;
   logic [DATA_W-1:0] next_change;
   logic drive;
   logic next_drive;
   php_pkg::php_state_t state;
   php_pkg::php_state_t next_state;

   logic muxed;
   logic parallel;
   logic moto;
   logic rd_act;
   logic wr_act;
   logic ale_rise;
   logic wr_end;
   logic wr_start;
   logic [ADDR_W-1:0] addr;

   // Status address test, shared by the read and write paths
   function automatic logic is_status(input logic [ADDR_W-1:0] a);
      is_status = (a == php_pkg::STATUS_ADDR);
   endfunction : is_status

   // Register read decode, used for host reads
   function automatic logic [DATA_W-1:0] reg_read(
      input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] st,
      input logic [DATA_W-1:0] ch,
      input logic [DATA_W-1:0] c
   );
      if (is_status(a)) begin
         reg_read = st | ch;
      end else begin
         reg_read = c;
      end
   endfunction : reg_read

   // Serial and hardware strap codes shut the port off
   assign parallel = ~i_bus_interface_select[1];
   assign muxed = (i_bus_interface_select == php_pkg::SEL_MUXED);
   assign moto = i_bus_type_select;

   // Address source by mode; mux mode ignores the address pins
   assign addr = muxed ? addr_latch : i_host_address_lines;

   // Strobe decode; chip select gates every access
   always_comb begin
      if (moto) begin
         rd_act = ~i_read_or_data_strobe_n
            & i_write_or_read_write_n;
         wr_act = ~i_read_or_data_strobe_n & ~i_write_or_read_write_n;
      end else begin
         rd_act = ~i_read_or_data_strobe_n;
         wr_act = ~i_write_or_read_write_n;
      end
      rd_act = rd_act & ~i_chip_select_n & parallel;
      wr_act = wr_act & ~i_chip_select_n & parallel;
   end

   php_edge u_ale_edge (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(i_address_latch_strobe),
      .o_rise(ale_rise),
      .o_fall()
   );

   php_edge u_wr_edge (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(wr_act),
      .o_rise(wr_start),
      .o_fall()
   );

   // Write commits on the strobe's trailing edge, when data is settled
   assign wr_end = (state == php_pkg::PHP_WRITE) & ~wr_act;

   always_comb begin
      next_state = state;
      next_addr_latch = addr_latch;
      next_ctrl = ctrl;
      next_drive = 1'b0;
      next_rd_data = rd_data;
      next_status_prev = i_status;
      // Change flags catch status pulses the host would miss
      next_change = change | (i_status ^ status_prev);
      if (muxed && ale_rise) begin
         next_addr_latch = i_host_data_lines[ADDR_W-1:0];
      end
      case (state)
         php_pkg::PHP_IDLE: begin
            if (rd_act) begin
               next_state = php_pkg::PHP_READ;
            end else if (wr_start) begin
               next_state = php_pkg::PHP_WRITE;
            end
         end
         php_pkg::PHP_READ: begin
            next_drive = rd_act;
            // Slot 0 is status, so slot 1 stands in and is never used
            next_rd_data = reg_read(addr, i_status, change,
               ctrl[is_status(addr) ? 1 : addr]);
            if (!rd_act) begin
               next_state = php_pkg::PHP_IDLE;
               if (is_status(addr)) begin
                  // Reading status clears change flags; new events still win
                  next_change = i_status ^ status_prev;
               end
            end
         end
         php_pkg::PHP_WRITE: begin
            if (wr_end) begin
               // Status is read-only; writes to it are dropped
               if (!is_status(addr)) begin
                  next_ctrl[addr] = i_host_data_lines;
               end
               next_state = php_pkg::PHP_IDLE;
            end
         end
         default: begin
            next_state = php_pkg::PHP_IDLE;
         end
      endcase
      // Reset pin overrides any access in flight
      if (!i_hardware_reset_n) begin
         for (int k = 1; k < NREG; k++) begin
            next_ctrl[k] = php_pkg::CTRL_RESET;
         end
         next_change = '0;
         next_state = php_pkg::PHP_IDLE;
         next_drive = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= php_pkg::PHP_IDLE;
         addr_latch <= '0;
         rd_data <= '0;
         drive <= 1'b0;
         status_prev <= '0;
         change <= '0;
         for (int k = 1; k < NREG; k++) begin
            ctrl[k] <= php_pkg::CTRL_RESET;
         end
      end else begin
         state <= next_state;
         addr_latch <= next_addr_latch;
         rd_data <= next_rd_data;
         drive <= next_drive;
         status_prev <= next_status_prev;
         change <= next_change;
         ctrl <= next_ctrl;
      end
   end

   // Release at once when the read strobe ends, avoiding bus fight
   assign o_host_data_lines = rd_data;
   assign o_host_data_lines_oe_n = ~(drive & rd_act);

   // Open drain: only ever pull low
   assign o_interrupt_n = 1'b0;
   assign o_interrupt_oe_n = ~(|(i_status | change));

   genvar g;
   generate
      for (g = 1; g < NREG; g++) begin : g_ctrl
         assign o_ctrl_flat[g] = ctrl[g];
      end
   endgenerate
endmodule : php_port

// *** core/php_pkg.sv ***
// Constants for the parallel host bus port
package php_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int REG_CNT = 32;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] SEL_MUXED = 2'h0;
   localparam logic [1:0] SEL_NONMUXED = 2'h1;
   localparam logic [1:0] SEL_SERIAL = 2'h2;
   localparam logic [1:0] SEL_HARDWARE = 2'h3;
   localparam logic [4:0] STATUS_ADDR = 5'h00;
   typedef enum logic [1:0] {
      PHP_IDLE,
      PHP_READ,
      PHP_WRITE
   } php_state_t;
endpackage : php_pkg

// *** core/php_edge.sv ***
// Rising and falling edge detector for one host strobe
`timescale 1ns/100ps
module php_edge (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Level in
   input wire logic i_level,
   // Edge pulses out
   output logic o_rise,
   output logic o_fall
);
   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = i_level;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   assign o_rise = i_level & ~prev;
   assign o_fall = ~i_level & prev;
endmodule : php_edge

// *** testbench/php_port_chk.sv ***
// Assertions on the parallel host bus port
`timescale 1ns/100ps
module php_port_chk (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Mode straps
   input wire logic [1:0] i_bus_interface_select,
   input wire logic i_bus_type_select,
   // Host bus controls
   input wire logic i_chip_select_n,
   input wire logic i_read_or_data_strobe_n,
   input wire logic i_write_or_read_write_n,
   input wire logic i_hardware_reset_n,
   // Data lines and interrupt
   input wire logic [7:0] o_host_data_lines,
   input wire logic o_host_data_lines_oe_n,
   input wire logic o_interrupt_n,
   input wire logic o_interrupt_oe_n,
   // Device side
   input wire logic [7:0] i_status,
   input wire logic [7:0] o_ctrl_flat [1:31]
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire rd_act = !i_chip_select_n && !i_bus_interface_select[1] &&
      !i_read_or_data_strobe_n &&
      (i_write_or_read_write_n || !i_bus_type_select);
   wire oe = !o_host_data_lines_oe_n;
   sequence s_rd_start;
      $rose(rd_act);
   endsequence
   a_read_drive: assert property (
      s_rd_start |-> ##[1:3] oe) else $error("read data late");
   a_oe_release: assert property (
      !rd_act |-> !oe) else $error("data driven outside read");
   a_data_hold: assert property (
      oe ##1 oe |-> $stable(o_host_data_lines)) else $error("data moved");
   a_cs_nowrite: assert property (
      i_chip_select_n [*3] ##0 i_hardware_reset_n |=>
      $stable(o_ctrl_flat[1])) else $error("write without select");
   a_hardware_reset_n_clear: assert property (
      !i_hardware_reset_n |=> o_ctrl_flat[1] == 8'h00)
      else $error("control not cleared");
   a_hardware_reset_n_hold: assert property (
      (!i_hardware_reset_n) [*2] |-> o_ctrl_flat[31] == 8'h00)
      else $error("control not held clear");
   a_int_status: assert property (
      (|i_status) |-> ##[0:2] !o_interrupt_oe_n) else $error("no interrupt");
   a_int_level: assert property (
      !o_interrupt_n) else $error("interrupt level wrong");
   a_int_change: assert property (
      $changed(i_status) |=> !o_interrupt_oe_n)
      else $error("no interrupt on status change");
endmodule : php_port_chk
bind php_port php_port_chk i_php_port_chk (.i_clk_sys, .i_rst,
   .i_bus_type_select, .i_chip_select_n, .i_read_or_data_strobe_n,
   .i_write_or_read_write_n, .i_hardware_reset_n, .o_host_data_lines_oe_n,
   .o_interrupt_n, .o_interrupt_oe_n, .i_bus_interface_select, .i_status,
   .o_host_data_lines, .o_ctrl_flat);

// *** testbench/php_host.sv ***
// Host processor model driving the parallel port
`timescale 1ns/100ps
module php_host (
   // Clock, mode and bus level
   input wire logic i_clk,
   input wire logic i_mux,
   input wire logic i_bts,
   input wire logic [7:0] i_data,
   // Host drive
   output logic o_cs_n = 1'b1,
   output logic o_rd_n = 1'b1,
   output logic o_wr_n = 1'b1,
   output logic o_ale = 1'b0,
   output logic [4:0] o_addr = 5'h00,
   output logic [7:0] o_data = 8'h00
);
   logic cs_on = 1'b1;
   task acc(input logic we, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_clk) #1;
      o_addr = i_mux ? 5'h00 : a;
      if (i_mux) begin
         o_data = {3'h0, a};
         o_ale = 1'b1;
         repeat (2) @(posedge i_clk) #1;
         o_ale = 1'b0;
      end
      o_data = d;
      o_cs_n = !cs_on;
      if (i_bts) begin
         o_wr_n = !we;
         o_rd_n = 1'b0;
      end else if (we) o_wr_n = 1'b0;
      else o_rd_n = 1'b0;
      // Read byte taken once the launching edge has settled
      repeat (4) @(posedge i_clk) #1;
      q = i_data;
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      @(posedge i_clk) #1;
      // Released bus must not keep the old byte
      o_data = ~d;
      repeat (2) @(posedge i_clk) #1;
   endtask : acc
endmodule : php_host

// *** testbench/php_port_tb.sv ***
// Self-checking bench for the parallel host bus port
`timescale 1ns/100ps
module php_port_tb;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic hardware_reset_n_n = 1'b1;
   logic bts = 1'b0;
   logic [1:0] bis = 2'h1;
   logic [7:0] st = 8'h00;
   logic [7:0] q, hd, dout;
   logic cs_n, rd_n, wr_n, ale, oe_n, int_n, int_oe_n;
   logic [4:0] ha;
   logic [7:0] ctrl [1:31];
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   wire [7:0] bus = oe_n ? hd : dout;
   always #2 i_clk_sys = ~i_clk_sys;
   php_port i_php_port (.i_clk_sys, .i_rst, .i_bus_interface_select(bis),
      .i_bus_type_select(bts), .i_chip_select_n(cs_n),
      .i_read_or_data_strobe_n(rd_n), .i_write_or_read_write_n(wr_n),
      .i_address_latch_strobe(ale), .i_hardware_reset_n(hardware_reset_n_n),
      .i_host_address_lines(ha), .i_host_data_lines(bus),
      .o_host_data_lines(dout), .o_host_data_lines_oe_n(oe_n),
      .o_interrupt_n(int_n), .o_interrupt_oe_n(int_oe_n), .i_status(st),
      .o_ctrl_flat(ctrl));
   php_host i_php_host (.i_clk(i_clk_sys), .i_mux(bis == 2'h0), .i_bts(bts),
      .i_data(bus), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
      .o_ale(ale), .o_addr(ha), .o_data(hd));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task t_nonmux;
      for (int b = 0; b < 2; b++) begin
         bts = b[0];
         i_php_host.acc(1'b1, 5'h01, 8'hA5 ^ b[7:0], q);
         i_php_host.acc(1'b1, 5'h1F, 8'h5A, q);
         i_php_host.acc(1'b0, 5'h01, 8'h00, q);
         chk("rd1", 8'hA5 ^ b[7:0], q);
         chk("ctrl31", 8'h5A, ctrl[31]);
      end
   endtask : t_nonmux
   task t_mux;
      bis = 2'h0;
      for (int b = 0; b < 2; b++) begin
         bts = b[0];
         i_php_host.acc(1'b1, 5'h07, 8'h3C ^ b[7:0], q);
         i_php_host.acc(1'b0, 5'h07, 8'h00, q);
         chk("mux", 8'h3C ^ b[7:0], q);
         chk("ctrl7", 8'h3C ^ b[7:0], ctrl[7]);
      end
      bis = 2'h1;
   endtask : t_mux
   task t_refuse;
      i_php_host.cs_on = 1'b0;
      i_php_host.acc(1'b1, 5'h02, 8'hFF, q);
      i_php_host.cs_on = 1'b1;
      bis = 2'h2;
      i_php_host.acc(1'b1, 5'h03, 8'hFF, q);
      bis = 2'h1;
      chk("cs", 8'h00, ctrl[2]);
      chk("bis", 8'h00, ctrl[3]);
   endtask : t_refuse
   task t_int;
      st = 8'h10;
      repeat (3) @(posedge i_clk_sys) #1;
      chk("int_on", 8'h00, {7'h00, int_oe_n});
      st = 8'h00;
      i_php_host.acc(1'b0, 5'h00, 8'h00, q);
      chk("stat", 8'h10, q);
      chk("int_off", 8'h01, {7'h00, int_oe_n});
   endtask : t_int
   task t_hardware_reset_n;
      hardware_reset_n_n = 1'b0;
      repeat (2) @(posedge i_clk_sys) #1;
      hardware_reset_n_n = 1'b1;
      chk("hrst1", 8'h00, ctrl[1]);
      chk("hrst7", 8'h00, ctrl[7]);
   endtask : t_hardware_reset_n
   task results;
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Hang guard, far above the roughly 125 cycles needed
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk_sys) #1;
      i_rst = 1'b0;
      chk("rst31", 8'h00, ctrl[31]);
      t_nonmux();
      t_mux();
      t_refuse();
      t_int();
      t_hardware_reset_n();
      results();
   end
endmodule : php_port_tb
